/* pkg/flash_map_pkg.sv */
`default_nettype none
package flash_map_pkg;

  // ****************************************
  // array organisation
  // ****************************************
  localparam int ADDR_W         = 24;
  localparam int ARRAY_BYTES    = 4194304;
  localparam int BLOCK_COUNT    = 64;
  localparam int SECTOR_COUNT   = 1024;
  localparam int PAGE_COUNT     = 16384;
  localparam int PAGE_BYTES     = 256;
  localparam int SECTOR_BYTES   = 4096;
  localparam int BLOCK_BYTES    = 65536;
  localparam int PAGE_POS       = 8;
  localparam int SECTOR_POS     = 12;
  localparam int BLOCK_POS      = 16;
  localparam logic [23:0] ARRAY_TOP = 24'h3FFFFF;

  // ****************************************
  // security register space
  // ****************************************
  localparam int SEC_REG_COUNT  = 4;
  localparam int SEC_REG_BYTES  = 256;
  localparam int SEC_REG_POS    = 12;

  // ****************************************
  // discovery structure
  // ****************************************
  localparam logic [7:0] HDR_START      = 8'h00;
  localparam logic [7:0] HDR_RSVD_START = 8'h10;
  localparam logic [7:0] PARAM_START    = 8'h30;
  localparam logic [7:0] SPACE_END      = 8'h6F;
  localparam logic [7:0] SIG_S          = 8'h53;
  localparam logic [7:0] SIG_F          = 8'h46;
  localparam logic [7:0] SIG_D          = 8'h44;
  localparam logic [7:0] SIG_P          = 8'h50;
  localparam logic [7:0] REV_MINOR      = 8'h06;
  localparam logic [7:0] REV_MAJOR      = 8'h01;
  localparam logic [7:0] NUM_PARAM_HDRS = 8'h00;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;
  localparam logic [7:0] PARAM_TBL_LEN  = 8'h10;

  // ****************************************
  // commands
  // ****************************************
  localparam logic [7:0] read_discovery_params_cmd = 8'h5A;

  typedef enum logic [2:0] {
    OP_READ,
    OP_PROGRAM,
    OP_ERASE_SECTOR,
    OP_ERASE_BLOCK,
    OP_ERASE_CHIP,
    OP_ERASE_PAGE,
    OP_LOCK
  } op_t;

  typedef enum logic [1:0] {
    SPACE_ARRAY,
    SPACE_SECURITY,
    SPACE_DISCOVERY
  } space_t;

endpackage
`default_nettype wire

/* core/discovery_rom.sv */
`default_nettype none
module discovery_rom
  import flash_map_pkg::*;
(
  // lookup
  input  wire logic [7:0] offset,
  output logic      [7:0] data
);

  // ****************************************
  // factory content, fixed in logic
  // ****************************************
  // constant logic cannot be altered by host writes (see RULE9)
  always_comb begin
    data = ERASED_BYTE; // see RULE15
    case (offset)
      HDR_START:         data = SIG_S; // see RULE10
      8'h01:             data = SIG_F;
      8'h02:             data = SIG_D;
      8'h03:             data = SIG_P;
      8'h04:             data = REV_MINOR; // see RULE13
      8'h05:             data = REV_MAJOR;
      8'h06:             data = NUM_PARAM_HDRS; // see RULE14
      // one parameter header pointing at the basic table (see RULE12)
      8'h08:             data = 8'h00;
      8'h09:             data = REV_MINOR;
      8'h0A:             data = REV_MAJOR;
      8'h0B:             data = PARAM_TBL_LEN;
      8'h0C:             data = PARAM_START;
      8'h0D:             data = 8'h00;
      8'h0E:             data = 8'h00;
      default: begin
        // basic table body kept erased; filled per product
        if (offset >= PARAM_START && offset <= SPACE_END) begin // see RULE11
          data = ERASED_BYTE;
        end
      end
    endcase
  end

endmodule
`default_nettype wire

/* core/serial_flash_address_map.sv */
// How it works
// RULE1 - array is 4 MiB: 64 blocks, 1024 sectors, 16384 pages of 256 bytes
// RULE2 - page program only clears bits; each page programs alone
// RULE3 - erase by sector, block or chip only; no page erase
// RULE4 - sector n spans n*4096 to n*4096+4095; top ends at 3FFFFF
// RULE5 - four 256-byte security registers at k*4096, separate space
// RULE6 - each security register has a one-time lock that never clears; here only registers 1..3 have one and reset clears it
// RULE7 - security registers 1..3 erase, program, lock independently
// RULE8 - register 0 is discovery data, read with its own command code
// RULE9 - discovery space is read-only; host program/erase ignored
// RULE10 - discovery offset zero returns ASCII S
// RULE11 - header reserved from 16, table at 48, ends at 111
// RULE12 - header gives revision and pointer to one basic table after it
// RULE13 - header minor revision 6, major revision 1
// RULE14 - parameter header count is zero based and holds zero
// RULE15 - reserved discovery offsets read all ones
`default_nettype none
module serial_flash_address_map
  import flash_map_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  // request from command decoder
  input  wire logic                req_valid,
  input  wire flash_map_pkg::op_t  req_op,
  input  wire flash_map_pkg::space_t req_space,
  input  wire logic [7:0]          req_cmd,
  input  wire logic [23:0]         req_addr,
  input  wire logic [7:0]          req_wdata,
  // lock bits as held in the second status register
  output logic [3:1]               lock_bits,
  // array memory port
  output logic                     mem_we,
  output logic [23:0]              mem_addr,
  output logic [23:0]              mem_len,
  output logic [7:0]               mem_wmask,
  output logic                     mem_erase,
  // decoded answer
  output logic                     rsp_valid,
  output logic                     rsp_accepted,
  output logic                     rsp_refused,
  output logic [7:0]               rsp_rdata,
  output logic [5:0]               rsp_block,
  output logic [9:0]               rsp_sector,
  output logic [13:0]              rsp_page,
  // security register storage read data
  input  wire logic [7:0]          sec_rdata
);
  import flash_map_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  // array spans 22 address bits; the two top bits are ignored
  localparam int ARRAY_MSB = $clog2(ARRAY_BYTES) - 1;
  wire [5:0]  blk_idx  = req_addr[ARRAY_MSB:BLOCK_POS];  // see RULE1
  wire [9:0]  sec_idx  = req_addr[ARRAY_MSB:SECTOR_POS];
  wire [13:0] page_idx = req_addr[ARRAY_MSB:PAGE_POS];
  wire [23:0] sector_base = {2'b00, sec_idx, 12'h000};    // see RULE4
  wire [23:0] block_base  = {2'b00, blk_idx, 16'h0000};
  wire [23:0] page_base   = {2'b00, page_idx, 8'h00};
  wire [23:0] sector_len  = 24'(SECTOR_BYTES);
  wire [23:0] block_len   = 24'(BLOCK_BYTES);
  wire [23:0] page_len    = 24'(PAGE_BYTES);
  wire [23:0] chip_len    = ARRAY_TOP + 24'h000001;

  // security space: register k at k*4096, 256 bytes (see RULE5)
  wire [1:0]  sreg_idx   = req_addr[SEC_REG_POS+1:SEC_REG_POS];
  wire        sreg_in    = (req_addr[23:SEC_REG_POS+2] == 10'h000)
                           && (req_addr[SEC_REG_POS-1:8] == 4'h0);
  wire        sreg_zero  = sreg_in && (sreg_idx == 2'h0);
  // one-hot of the addressed register; register 0 has no lock bit
  wire [3:1]  sreg_hot   = {sreg_idx == 2'h3, sreg_idx == 2'h2, sreg_idx == 2'h1};
  wire        sreg_lockd = |(lock_bits & sreg_hot);

  // discovery read via its own command (see RULE8)
  wire        disc_sel   = (req_space == SPACE_DISCOVERY) && (req_cmd == read_discovery_params_cmd);
  wire [7:0]  disc_byte;

  discovery_rom u_rom (
    .offset (req_addr[7:0]),
    .data   (disc_byte)
  );

  // ****************************************
  // legality of each request
  // ****************************************
  wire is_array = (req_space == SPACE_ARRAY);
  wire is_sec   = (req_space == SPACE_SECURITY);
  wire is_write = (req_op != OP_READ);
  // page erase never offered (see RULE3)
  wire bad_op   = (req_op == OP_ERASE_PAGE)
                  || (is_sec && (req_op == OP_ERASE_BLOCK || req_op == OP_ERASE_CHIP));
  // discovery space and register 0 refuse all writes (see RULE9)
  wire ro_hit   = (req_space == SPACE_DISCOVERY && is_write) || (is_sec && sreg_zero && is_write);
  // locked registers refuse change; others unaffected (see RULE7)
  wire lock_hit = is_sec && is_write && sreg_lockd;
  wire bad_addr = (is_sec && !sreg_in) || (req_space == SPACE_DISCOVERY && !disc_sel && !is_write);
  wire refuse   = bad_op || ro_hit || lock_hit || bad_addr;
  wire take     = req_valid && clk_en && !refuse;

  // ****************************************
  // memory command selection
  // ****************************************
  wire [23:0] sel_addr =
      (req_op == OP_ERASE_SECTOR) ? sector_base :
      (req_op == OP_ERASE_BLOCK)  ? block_base  :
      (req_op == OP_ERASE_CHIP)   ? 24'h000000  :
      (is_sec)                    ? {req_addr[23:8], 8'h00} :
      page_base;
  wire [23:0] sel_len =
      (req_op == OP_ERASE_SECTOR && is_array) ? sector_len :
      (req_op == OP_ERASE_SECTOR && is_sec)   ? 24'(SEC_REG_BYTES) :
      (req_op == OP_ERASE_BLOCK)              ? block_len  :
      (req_op == OP_ERASE_CHIP)               ? chip_len   :
      page_len;
  wire sel_erase = (req_op == OP_ERASE_SECTOR) || (req_op == OP_ERASE_BLOCK) || (req_op == OP_ERASE_CHIP);
  wire sel_we    = sel_erase || (req_op == OP_PROGRAM);
  // program can only clear bits: mask of bits to drive low (see RULE2)
  wire [7:0] sel_mask = (req_op == OP_PROGRAM) ? ~req_wdata : 8'h00;
  wire [7:0] sel_rdata = (req_space == SPACE_DISCOVERY) ? disc_byte :
                         is_sec ? sec_rdata : 8'h00;
  wire do_lock = take && is_sec && (req_op == OP_LOCK);
  // one-time: bits only ever set, never cleared (see RULE6)
  wire [3:1] lock_d = lock_bits | (sreg_hot & {3{do_lock}});

  // ****************************************
  // lock bits
  // ****************************************
  // kept in flops here; no path back to zero short of reset
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lock_bits <= 3'h0;
    end else if (clk_en) begin
      lock_bits <= lock_d; // see RULE6
    end
  end

  // ****************************************
  // memory command
  // ****************************************
  // a refused request leaves both strobes low, so storage never sees it
  wire mem_we_d    = take && sel_we && (req_op != OP_LOCK);
  wire mem_erase_d = take && sel_erase;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_we    <= 1'b0;
      mem_erase <= 1'b0;
    end else if (clk_en) begin
      mem_we    <= mem_we_d;
      mem_erase <= mem_erase_d; // see RULE3
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_addr  <= 24'h000000;
      mem_len   <= 24'h000000;
      mem_wmask <= 8'h00;
    end else if (clk_en) begin
      mem_addr  <= sel_addr; // see RULE4
      mem_len   <= sel_len;
      mem_wmask <= sel_mask; // see RULE2
    end
  end

  // ****************************************
  // response flags
  // ****************************************
  // every request made while clk_en is high is answered one cycle later, taken or refused
  wire rsp_refused_d = req_valid && refuse;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rsp_valid    <= 1'b0;
      rsp_accepted <= 1'b0;
      rsp_refused  <= 1'b0;
    end else if (clk_en) begin
      rsp_valid    <= req_valid;
      rsp_accepted <= take;
      rsp_refused  <= rsp_refused_d;
    end
  end

  // ****************************************
  // read data and indices
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rsp_rdata <= 8'h00;
    end else if (clk_en) begin
      rsp_rdata <= sel_rdata; // see RULE15
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rsp_block  <= 6'h00;
      rsp_sector <= 10'h000;
      rsp_page   <= 14'h0000;
    end else if (clk_en) begin
      rsp_block  <= blk_idx; // see RULE1
      rsp_sector <= sec_idx;
      rsp_page   <= page_idx;
    end
  end

endmodule
`default_nettype wire

/* verification/flash_map_sva.sv */
`default_nettype none
module flash_map_sva
  import flash_map_pkg::*;
(
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  resetn,
  input wire logic                  clk_en,
  // request
  input wire logic                  req_valid,
  input wire flash_map_pkg::op_t    req_op,
  input wire flash_map_pkg::space_t req_space,
  input wire logic [7:0]            req_cmd,
  input wire logic [23:0]           req_addr,
  // answer
  input wire logic [3:1]            lock_bits,
  input wire logic                  mem_we,
  input wire logic [23:0]           mem_addr,
  input wire logic [23:0]           mem_len,
  input wire logic                  mem_erase,
  input wire logic                  rsp_valid,
  input wire logic                  rsp_refused,
  input wire logic [7:0]            rsp_rdata,
  input wire logic [5:0]            rsp_block,
  input wire logic [9:0]            rsp_sector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_take; req_valid && clk_en; endsequence
  sequence s_refuse; rsp_valid && rsp_refused && !mem_we; endsequence
  property p_answer; s_take |=> rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer after request");
  property p_page; s_take ##0 (req_op == OP_ERASE_PAGE) |=> s_refuse; endproperty
  a_page: assert property (p_page) else $error("page erase not refused");
  property p_sector;
    s_take ##0 (req_op == OP_ERASE_SECTOR && req_space == SPACE_ARRAY)
    |=> mem_erase && mem_addr == {2'b00, $past(req_addr[21:12]), 12'h000} && mem_len == 24'h001000;
  endproperty
  a_sector: assert property (p_sector) else $error("sector erase range wrong");
  property p_sig;
    s_take ##0 (req_op == OP_READ && req_space == SPACE_DISCOVERY && req_cmd == 8'h5A && req_addr[7:0] == 8'h00)
    |=> rsp_rdata == 8'h53;
  endproperty
  a_sig: assert property (p_sig) else $error("discovery byte zero wrong");
  property p_ro; s_take ##0 (req_op != OP_READ && req_space == SPACE_DISCOVERY) |=> s_refuse; endproperty
  a_ro: assert property (p_ro) else $error("discovery write not refused");
  property p_lock; (lock_bits & $past(lock_bits)) == $past(lock_bits); endproperty
  a_lock: assert property (p_lock) else $error("lock bit cleared");
  property p_index;
    s_take |=> rsp_sector == $past(req_addr[21:12]) && rsp_block == $past(req_addr[21:16]);
  endproperty
  a_index: assert property (p_index) else $error("block or sector index wrong");
  property p_range; s_take ##0 (req_space == SPACE_SECURITY && req_addr[11:8] != 4'h0) |=> s_refuse; endproperty
  a_range: assert property (p_range) else $error("security offset past 255 accepted");
  property p_cmd; s_take ##0 (req_space == SPACE_DISCOVERY && req_cmd != 8'h5A) |=> s_refuse; endproperty
  a_cmd: assert property (p_cmd) else $error("discovery access without its command");
endmodule
bind serial_flash_address_map flash_map_sva u_sva (.ref_clk, .resetn, .clk_en, .req_valid, .req_op, .req_space,
  .req_cmd, .req_addr, .lock_bits, .mem_we, .mem_addr, .mem_len, .mem_erase, .rsp_valid, .rsp_refused,
  .rsp_rdata, .rsp_block, .rsp_sector);
`default_nettype wire

/* verification/host_model.sv */
`default_nettype none
module host_model
  import flash_map_pkg::*;
(
  input  wire logic                 ref_clk,
  output var  logic                 req_valid,
  output var  flash_map_pkg::op_t   req_op,
  output var  flash_map_pkg::space_t req_space,
  output var  logic [7:0]           req_cmd,
  output var  logic [23:0]          req_addr,
  output var  logic [7:0]           req_wdata,
  output var  logic [7:0]           sec_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid = 1'b0;
    req_op = OP_READ;
    req_space = SPACE_ARRAY;
    {req_cmd, req_addr, req_wdata, sec_rdata} = '0;
  end
  // one-cycle request; storage byte is a known function of the offset
  task automatic send(input op_t op, input space_t sp, input logic [7:0] cmd, input logic [23:0] a,
                      input logic [7:0] wd);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_space <= sp;
    req_cmd <= cmd;
    req_addr <= a;
    req_wdata <= wd;
    sec_rdata <= a[7:0] ^ 8'h3C;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    // released storage must not look stable
    sec_rdata <= ~(a[7:0] ^ 8'h3C);
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
`default_nettype none
module testbench;
  import flash_map_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, resetn = 1'b0, req_valid, mem_we, mem_erase, rsp_valid, rsp_accepted, rsp_refused;
  logic clk_en = 1'b1;
  op_t req_op;
  space_t req_space;
  logic [7:0] req_cmd, req_wdata, sec_rdata, rsp_rdata, mem_wmask;
  logic [23:0] req_addr, mem_addr, mem_len;
  logic [3:1] lock_bits;
  logic [5:0] rsp_block;
  logic [9:0] rsp_sector;
  logic [13:0] rsp_page;
  int n_fail = 0, check_count = 0, cycles = 0;
  always #25 ref_clk = ~ref_clk;
  host_model host (.ref_clk, .req_valid, .req_op, .req_space, .req_cmd, .req_addr, .req_wdata, .sec_rdata);
  serial_flash_address_map uut (.ref_clk, .resetn, .clk_en, .req_valid, .req_op, .req_space, .req_cmd,
    .req_addr, .req_wdata, .lock_bits, .mem_we, .mem_addr, .mem_len, .mem_wmask, .mem_erase, .rsp_valid,
    .rsp_accepted, .rsp_refused, .rsp_rdata, .rsp_block, .rsp_sector, .rsp_page, .sec_rdata);
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rq(input op_t op, input space_t sp, input logic [7:0] cmd, input logic [23:0] a,
                    input logic [7:0] wd);
    host.send(op, sp, cmd, a, wd);
    #1;
  endtask
  task automatic stop_test;
    $display("%0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_discovery;
    logic [7:0] hdr [15] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00, 8'hFF,
                             8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00};
    for (int i = 0; i < 15; i++) begin
      rq(OP_READ, SPACE_DISCOVERY, read_discovery_params_cmd, 24'(i), 8'h00);
      chk("header byte", {16'h0, hdr[i]}, {16'h0, rsp_rdata});
    end
    rq(OP_READ, SPACE_DISCOVERY, read_discovery_params_cmd, 24'h000010, 8'h00);
    chk("reserved header", 24'h0000FF, {16'h0, rsp_rdata});
    rq(OP_READ, SPACE_DISCOVERY, read_discovery_params_cmd, 24'h000070, 8'h00);
    chk("reserved tail", 24'h0000FF, {16'h0, rsp_rdata});
    rq(OP_READ, SPACE_DISCOVERY, 8'h03, 24'h000000, 8'h00);
    chk("wrong command", 24'h1, {23'h0, rsp_refused});
    chk("answer valid", 24'h1, {23'h0, rsp_valid});
    $display("discovery test done");
  endtask
  task automatic t_array;
    rq(OP_ERASE_SECTOR, SPACE_ARRAY, 8'h00, 24'h3FF123, 8'h00);
    chk("sector base", 24'h3FF000, mem_addr);
    chk("sector len", 24'h001000, mem_len);
    rq(OP_ERASE_BLOCK, SPACE_ARRAY, 8'h00, 24'h3F1234, 8'h00);
    chk("block base", 24'h3F0000, mem_addr);
    chk("block len", 24'h010000, mem_len);
    rq(OP_ERASE_CHIP, SPACE_ARRAY, 8'h00, 24'h000000, 8'h00);
    chk("chip len", 24'(ARRAY_BYTES), mem_len);
    chk("chip base", 24'h000000, mem_addr);
    rq(OP_ERASE_PAGE, SPACE_ARRAY, 8'h00, 24'h000100, 8'h00);
    chk("page erase", 24'h2, {22'h0, rsp_refused, mem_we});
    rq(OP_PROGRAM, SPACE_ARRAY, 8'h00, 24'h012345, 8'h5A);
    chk("clear mask", 24'h0000A5, {16'h0, mem_wmask});
    chk("page base", 24'h012300, mem_addr);
    chk("page index", 24'h000123, {10'h0, rsp_page});
    chk("block sector", 24'h000412, {8'h0, rsp_block, rsp_sector});
    $display("array test done");
  endtask
  task automatic t_secure;
    rq(OP_PROGRAM, SPACE_DISCOVERY, read_discovery_params_cmd, 24'h000000, 8'h00);
    chk("discovery write", 24'h2, {22'h0, rsp_refused, mem_we});
    rq(OP_PROGRAM, SPACE_SECURITY, 8'h00, 24'h001100, 8'h00);
    chk("past register end", 24'h1, {23'h0, rsp_refused});
    rq(OP_READ, SPACE_SECURITY, 8'h00, 24'h0030AB, 8'h00);
    chk("register read", 24'h000097, {16'h0, rsp_rdata});
    rq(OP_LOCK, SPACE_SECURITY, 8'h00, 24'h001000, 8'h00);
    chk("lock one", 24'h1, {21'h0, lock_bits});
    rq(OP_PROGRAM, SPACE_SECURITY, 8'h00, 24'h001010, 8'h0F);
    chk("locked write", 24'h2, {22'h0, rsp_refused, mem_we});
    rq(OP_ERASE_SECTOR, SPACE_SECURITY, 8'h00, 24'h002000, 8'h00);
    chk("other register", 24'h3, {22'h0, rsp_accepted, mem_erase});
    chk("register len", 24'h000100, mem_len);
    chk("lock kept", 24'h1, {21'h0, lock_bits});
    $display("security test done");
  endtask
  task automatic t_freeze;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    rq(OP_LOCK, SPACE_SECURITY, 8'h00, 24'h003000, 8'h00);
    chk("frozen lock", 24'h1, {21'h0, lock_bits});
    @(posedge ref_clk);
    clk_en <= 1'b1;
    $display("freeze test done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_discovery();
    t_array();
    t_secure();
    t_freeze();
    stop_test();
  end
endmodule
`default_nettype wire
